/* rtl/rmc_defines.vh */
/*
 * Constants of the receive mode control block: register offsets, field
 * positions, reset values, antenna codes and timing counts.
 * Assumes it is included by bare name from every file of the block.
 */
// Summary of operation
// - antenna codes 110/111 run beacon diversity in receive; outside receive drive 00/11.
// - multi-packet set with FIFO mode and packet handling keeps receiving packets.
// - multi-packet clear with FIFO mode and packet handling leaves receive after one packet.
// - low-duty-cycle enable turns the receiver on periodically without host action.
// - writing clear bit 1 then 0 empties the receive FIFO.
// - seven-bit crystal load code in low bits drives the oscillator trim.
// - top bit of the trim register is a separate coarse capacitance shift control.
// - manual receive-on bit self-clears after a valid packet when multi-packet is off with FIFO mode and packet handling set.
// - gpio select codes 10111 and 11000 put antenna one and two on that pin.
`ifndef RMC_DEFINES_VH
`define RMC_DEFINES_VH

// register offsets
`define RMC_ADDR_OPMODE1  8'h07
`define RMC_ADDR_RXCTRL   8'h08
`define RMC_ADDR_XTAL     8'h09
`define RMC_ADDR_DCFG     8'h40
`define RMC_ADDR_STAT     8'h41

// field positions
`define RMC_SWRES_BIT     7
`define RMC_RXON_BIT      2
`define RMC_ANT_MSB       7
`define RMC_ANT_LSB       5
`define RMC_MPK_BIT       4
`define RMC_LDM_BIT       2
`define RMC_FFCLR_BIT     1
`define RMC_XSHFT_BIT     7
`define RMC_XLC_MSB       6
`define RMC_FIFOMODE_BIT  0
`define RMC_PKTRX_BIT     1

// reset values
`define RMC_OPMODE1_RST   8'h00
`define RMC_RXCTRL_RST    8'h00
`define RMC_XTAL_RST      8'h00
`define RMC_DCFG_RST      8'h00
`define RMC_RDATA_NONE    8'h00

// gpio function select codes
`define RMC_GPIO_SEL_W    5
`define RMC_GPIO_ANT1     5'h17
`define RMC_GPIO_ANT2     5'h18

// timing: antenna dwell during diversity search
`define RMC_CLK_MHZ       40
`define RMC_DWELL_NS      2000
`define RMC_DWELL_CYC     ((`RMC_DWELL_NS * `RMC_CLK_MHZ + 999) / 1000)

`endif

/* rtl/rmc_antdiv.v */
/*
 * Antenna switch driver: fixed antenna patterns and the diversity search,
 * plain or beacon variant.
 * Assumes rx_state_i, preamble_det_i and rssi_i are synchronous to the clock.
 */
`timescale 1ns/1ps
`include "rmc_defines.vh"

module rmc_antdiv #(
   parameter DWELL_CYC = `RMC_DWELL_CYC,
   parameter CNT_W     = 8
) (
   // clock and reset
   input  wire       core_clk_i,
   input  wire       rst_i,
   input  wire       ce_i,
   // control
   input  wire [2:0] mode_i,
   input  wire       rx_state_i,
   input  wire       preamble_det_i,
   input  wire [7:0] rssi_i,
   // antenna outputs
   output reg        ant1_o,
   output reg        ant2_o,
   output wire       locked_o
);

   localparam integer     DWELL_M1   = DWELL_CYC - 1;
   localparam [CNT_W-1:0] DWELL_LAST = DWELL_M1[CNT_W-1:0];

   reg             rx_d_ff;
   reg             sel_ff;
   reg             lock_ff;
   reg             win_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg [7:0]       rssi_a_ff;
   reg [7:0]       rssi_b_ff;
   reg             nxt_ant1;
   reg             nxt_ant2;

   wire algo   = mode_i[2];
   wire beacon = mode_i[2] & mode_i[1];

   assign locked_o = lock_ff;

   // ------------------------------------------------------------------
   // diversity search
   // ------------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         rx_d_ff   <= 1'b0;
         sel_ff    <= 1'b0;
         lock_ff   <= 1'b0;
         win_ff    <= 1'b0;
         cnt_ff    <= {CNT_W{1'b0}};
         rssi_a_ff <= 8'h00;
         rssi_b_ff <= 8'h00;
      end else if (ce_i) begin
         rx_d_ff <= rx_state_i;
         if (rx_state_i && !rx_d_ff) begin
            // beacon search starts on the last winning antenna
            sel_ff  <= beacon ? win_ff : 1'b0;
            lock_ff <= 1'b0;
            cnt_ff  <= {CNT_W{1'b0}};
         end else if (rx_state_i && algo && !lock_ff) begin
            if (preamble_det_i) begin
               lock_ff <= 1'b1;
               if (beacon) begin
                  win_ff <= sel_ff;
               end else begin
                  sel_ff <= (rssi_b_ff > rssi_a_ff);
                  win_ff <= (rssi_b_ff > rssi_a_ff);
               end
            end else if (cnt_ff == DWELL_LAST) begin
               cnt_ff <= {CNT_W{1'b0}};
               sel_ff <= ~sel_ff;
               if (sel_ff) begin
                  rssi_b_ff <= rssi_i;
               end else begin
                  rssi_a_ff <= rssi_i;
               end
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end else if (!rx_state_i) begin
            lock_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // antenna pattern
   // ------------------------------------------------------------------
   always @* begin
      if (!rx_state_i) begin
         nxt_ant1 = algo ? mode_i[0] : mode_i[1];
         nxt_ant2 = algo ? mode_i[0] : mode_i[1];
      end else if (algo) begin
         nxt_ant1 = ~sel_ff;
         nxt_ant2 = sel_ff;
      end else begin
         nxt_ant1 = mode_i[0];
         nxt_ant2 = ~mode_i[0];
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         ant1_o <= 1'b0;
         ant2_o <= 1'b0;
      end else if (ce_i) begin
         ant1_o <= nxt_ant1;
         ant2_o <= nxt_ant2;
      end
   end

endmodule

/* rtl/rmc_top.v */
/*
 * Receive mode control register bank: operating mode 1 and 2 registers,
 * crystal load trim, a data-path config register and a status register,
 * plus multi-packet, low-duty-cycle, FIFO clear and gpio antenna routing.
 * Assumes the host port strobes are one cycle wide and synchronous, and
 * that packet, wake-up and rx state inputs come from the rest of the radio.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "rmc_defines.vh"

module rmc_top #(
   parameter N_GPIO    = 3,
   parameter DWELL_CYC = `RMC_DWELL_CYC
) (
   // clock, reset, enable
   input  wire                          core_clk_i,
   input  wire                          rst_i,
   input  wire                          ce_i,
   // register port
   input  wire [7:0]                    addr_i,
   input  wire [7:0]                    wdata_i,
   input  wire                          wr_i,
   input  wire                          rd_i,
   output reg  [7:0]                    rdata_o,
   // receiver status
   input  wire                          rx_state_i,
   input  wire                          pkt_valid_i,
   input  wire                          preamble_det_i,
   input  wire [7:0]                    rssi_i,
   input  wire                          wut_expire_i,
   // gpio routing
   input  wire [N_GPIO*`RMC_GPIO_SEL_W-1:0] gpio_sel_i,
   output wire [N_GPIO-1:0]             gpio_ant_o,
   output wire [N_GPIO-1:0]             gpio_ant_oe_o,
   // receiver control
   output reg                           rx_on_o,
   output reg                           rx_exit_o,
   output reg                           ldc_wake_o,
   output wire                          ldc_en_o,
   output wire                          multi_pkt_o,
   output reg                           fifo_clr_o,
   // crystal trim
   output wire [6:0]                    xtal_trim_o,
   output wire                          xtal_shift_o,
   // antennas
   output wire                          ant1_o,
   output wire                          ant2_o
);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   reg  [7:0] opmode1_ff;
   reg  [7:0] rxctrl_ff;
   reg  [7:0] xtal_ff;
   reg  [7:0] dcfg_ff;
   reg        swres_ff;
   reg  [7:0] nxt_rdata;
   reg        nxt_rx_exit;
   reg        nxt_fifo_clr;

   wire       wr_op1  = wr_i && (addr_i == `RMC_ADDR_OPMODE1);
   wire       wr_rxc  = wr_i && (addr_i == `RMC_ADDR_RXCTRL);
   wire       wr_xtal = wr_i && (addr_i == `RMC_ADDR_XTAL);
   wire       wr_dcfg = wr_i && (addr_i == `RMC_ADDR_DCFG);

   wire       fifo_mode = dcfg_ff[`RMC_FIFOMODE_BIT];
   wire       pkt_rx_en = dcfg_ff[`RMC_PKTRX_BIT];
   wire       mpk       = rxctrl_ff[`RMC_MPK_BIT];
   wire       ffclr     = rxctrl_ff[`RMC_FFCLR_BIT];
   wire       pkt_mode  = fifo_mode & pkt_rx_en;
   wire       single_done = pkt_valid_i & rx_state_i & pkt_mode & ~mpk;
   wire       locked;

   // software reset takes effect one cycle after the write
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         swres_ff <= 1'b0;
      end else if (ce_i) begin
         swres_ff <= wr_op1 & wdata_i[`RMC_SWRES_BIT];
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i || (ce_i && swres_ff)) begin
         opmode1_ff <= `RMC_OPMODE1_RST;
         rxctrl_ff  <= `RMC_RXCTRL_RST;
         xtal_ff    <= `RMC_XTAL_RST;
         dcfg_ff    <= `RMC_DCFG_RST;
      end else if (ce_i) begin
         if (wr_op1) begin
            // a host write of rxon wins over the automatic clear
            opmode1_ff <= {1'b0, wdata_i[6:0]};
         end else if (single_done) begin
            opmode1_ff[`RMC_RXON_BIT] <= 1'b0;
         end
         if (wr_rxc) begin
            rxctrl_ff <= wdata_i;
         end
         if (wr_xtal) begin
            xtal_ff <= wdata_i;
         end
         if (wr_dcfg) begin
            dcfg_ff <= {6'h00, wdata_i[1:0]};
         end
      end
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   always @* begin
      if (addr_i == `RMC_ADDR_OPMODE1) begin
         nxt_rdata = opmode1_ff;
      end else if (addr_i == `RMC_ADDR_RXCTRL) begin
         nxt_rdata = rxctrl_ff;
      end else if (addr_i == `RMC_ADDR_XTAL) begin
         nxt_rdata = xtal_ff;
      end else if (addr_i == `RMC_ADDR_DCFG) begin
         nxt_rdata = dcfg_ff;
      end else if (addr_i == `RMC_ADDR_STAT) begin
         nxt_rdata = {4'h0, locked, rx_state_i, ant2_o, ant1_o};
      end else begin
         nxt_rdata = `RMC_RDATA_NONE;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         rdata_o <= rd_i ? nxt_rdata : 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // receive sequencing
   // ------------------------------------------------------------------
   assign multi_pkt_o = pkt_mode & mpk;
   assign ldc_en_o    = rxctrl_ff[`RMC_LDM_BIT];

   always @* begin
      nxt_rx_exit  = single_done;
      // fifo held empty while the bit is 1, cleared on the 1 then 0 write
      nxt_fifo_clr = wr_rxc ? wdata_i[`RMC_FFCLR_BIT] : ffclr;
   end

   always @(posedge core_clk_i) begin
      if (rst_i || (ce_i && swres_ff)) begin
         rx_on_o    <= 1'b0;
         rx_exit_o  <= 1'b0;
         ldc_wake_o <= 1'b0;
         fifo_clr_o <= 1'b0;
      end else if (ce_i) begin
         rx_on_o    <= opmode1_ff[`RMC_RXON_BIT];
         rx_exit_o  <= nxt_rx_exit;
         ldc_wake_o <= ldc_en_o & wut_expire_i;
         fifo_clr_o <= nxt_fifo_clr;
      end
   end

   // ------------------------------------------------------------------
   // crystal trim
   // ------------------------------------------------------------------
   assign xtal_trim_o  = xtal_ff[`RMC_XLC_MSB:0];
   assign xtal_shift_o = xtal_ff[`RMC_XSHFT_BIT];

   // ------------------------------------------------------------------
   // antenna driver and gpio routing
   // ------------------------------------------------------------------
   rmc_antdiv #(
      .DWELL_CYC (DWELL_CYC),
      .CNT_W     (8)
   ) u_antdiv (
      .core_clk_i     (core_clk_i),
      .rst_i          (rst_i),
      .ce_i           (ce_i),
      .mode_i         (rxctrl_ff[`RMC_ANT_MSB:`RMC_ANT_LSB]),
      .rx_state_i     (rx_state_i),
      .preamble_det_i (preamble_det_i),
      .rssi_i         (rssi_i),
      .ant1_o         (ant1_o),
      .ant2_o         (ant2_o),
      .locked_o       (locked)
   );

   // returns 1 for ant1, 2 for ant2, 0 for any other function
   function [1:0] rmc_ant_route;
      input [`RMC_GPIO_SEL_W-1:0] sel;
      begin
         if (sel == `RMC_GPIO_ANT1) begin
            rmc_ant_route = 2'h1;
         end else if (sel == `RMC_GPIO_ANT2) begin
            rmc_ant_route = 2'h2;
         end else begin
            rmc_ant_route = 2'h0;
         end
      end
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < N_GPIO; gi = gi + 1) begin : g_gpio
         wire [1:0] route = rmc_ant_route(
            gpio_sel_i[gi*`RMC_GPIO_SEL_W +: `RMC_GPIO_SEL_W]);
         assign gpio_ant_o[gi]    = (route[0] & ant1_o) | (route[1] & ant2_o);
         assign gpio_ant_oe_o[gi] = route[0] | route[1];
      end
   endgenerate

endmodule

/* dv/rmc_chk.sv */
/* checker for rmc_top: receive sequencing, fifo clear, trim and gpio routing.
   assumes one clock domain and the synchronous active-high reset. */
`timescale 1ns/1ps
`include "rmc_defines.vh"
module rmc_chk #(
   parameter N_GPIO = 3
) (
   // clock and reset
   input wire                              core_clk_i,
   input wire                              rst_i,
   input wire                              ce_i,
   // register port
   input wire [7:0]                        addr_i,
   input wire [7:0]                        wdata_i,
   input wire                              wr_i,
   // receiver side
   input wire                              pkt_valid_i,
   input wire                              rx_state_i,
   input wire                              wut_expire_i,
   input wire [N_GPIO*`RMC_GPIO_SEL_W-1:0] gpio_sel_i,
   // watched outputs
   input wire [N_GPIO-1:0]                 gpio_ant_o,
   input wire [N_GPIO-1:0]                 gpio_ant_oe_o,
   input wire                              rx_on_o,
   input wire                              rx_exit_o,
   input wire                              ldc_wake_o,
   input wire                              ldc_en_o,
   input wire                              multi_pkt_o,
   input wire                              fifo_clr_o,
   input wire [6:0]                        xtal_trim_o,
   input wire                              xtal_shift_o,
   input wire                              ant1_o,
   input wire                              ant2_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i || !ce_i);
   wire       wr08 = wr_i && addr_i == `RMC_ADDR_RXCTRL;
   wire       swr  = wr_i && addr_i == `RMC_ADDR_OPMODE1 && wdata_i[`RMC_SWRES_BIT];
   wire [4:0] sel0 = gpio_sel_i[4:0];
   wire       is1  = sel0 == `RMC_GPIO_ANT1;
   wire       is2  = sel0 == `RMC_GPIO_ANT2;
   a_exit_cause: assert property (rx_exit_o |-> $past(pkt_valid_i && rx_state_i && !multi_pkt_o))
      else $error("exit without a single-packet valid packet");
   a_multi_stays: assert property (multi_pkt_o && pkt_valid_i |=> !rx_exit_o)
      else $error("exit while multi-packet set");
   a_rxon_clear: assert property (rx_exit_o && !$past(wr_i && addr_i == `RMC_ADDR_OPMODE1)
      |=> !rx_on_o)
      else $error("receive-on not cleared");
   a_ldc_wake: assert property (!$past(swr, 2) |-> ldc_wake_o == $past(wut_expire_i && ldc_en_o))
      else $error("low duty wake mismatch");
   a_clr_set: assert property (wr08 && wdata_i[1] |=> fifo_clr_o)
      else $error("fifo clear not started");
   a_clr_end: assert property (wr08 && !wdata_i[1] |=> !fifo_clr_o)
      else $error("fifo clear not ended");
   a_clr_hold: assert property (fifo_clr_o && !wr_i && !$past(swr) |=> fifo_clr_o)
      else $error("fifo clear dropped");
   a_trim_split: assert property (wr_i && addr_i == `RMC_ADDR_XTAL
      |=> {xtal_shift_o, xtal_trim_o} == $past(wdata_i))
      else $error("trim outputs wrong");
   a_gpio_route: assert property (gpio_ant_oe_o[0] == (is1 || is2)
      && gpio_ant_o[0] == (is1 ? ant1_o : is2 && ant2_o))
      else $error("gpio antenna routing wrong");
   c_exit: cover property (rx_exit_o);
   c_clr: cover property (fifo_clr_o ##1 !fifo_clr_o);
   c_wake: cover property (ldc_wake_o);
endmodule
bind rmc_top rmc_chk #(.N_GPIO(N_GPIO)) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .ce_i(ce_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .pkt_valid_i(pkt_valid_i),
   .rx_state_i(rx_state_i), .wut_expire_i(wut_expire_i), .gpio_sel_i(gpio_sel_i),
   .gpio_ant_o(gpio_ant_o), .gpio_ant_oe_o(gpio_ant_oe_o), .rx_on_o(rx_on_o),
   .rx_exit_o(rx_exit_o), .ldc_wake_o(ldc_wake_o), .ldc_en_o(ldc_en_o),
   .multi_pkt_o(multi_pkt_o), .fifo_clr_o(fifo_clr_o), .xtal_trim_o(xtal_trim_o),
   .xtal_shift_o(xtal_shift_o), .ant1_o(ant1_o), .ant2_o(ant2_o));

/* dv/rmc_host_model.sv */
/* host model: master of the register port.
   assumes one clock; strobes launched just after a rising edge. */
`timescale 1ns/1ps
module rmc_host_model (
   // clock
   input  wire       core_clk_i,
   // register port
   output reg  [7:0] addr_o,
   output reg  [7:0] wdata_o,
   output reg        wr_o,
   output reg        rd_o,
   input  wire [7:0] rdata_i
);
   // bench routes antenna pins and sets fifo mode before use
   // wake period is outside the block; only its expiry pulse is driven
   initial begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // a released bus shows the inverse of the last value
   task wr(input [7:0] a, input [7:0] d);
      @(posedge core_clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge core_clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
      #1;
   endtask
   task rd(input [7:0] a, output [7:0] d);
      @(posedge core_clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge core_clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
endmodule

/* dv/tb_top.sv */
/* testbench for rmc_top: register, antenna, packet, low-duty and clear tests.
   assumes rmc_host_model drives the register port. */
`timescale 1ns/1ps
`include "rmc_defines.vh"
module tb_top;
   reg         core_clk_i, rst_i, ce_i, rx_state_i, pkt_valid_i, preamble_det_i, wut_expire_i;
   reg  [7:0]  rssi_i, rv;
   reg  [14:0] gpio_sel_i;
   wire [7:0]  addr_i, wdata_i, rdata_o;
   wire [6:0]  xtal_trim_o;
   wire [2:0]  gpio_ant_o, gpio_ant_oe_o;
   wire        wr_i, rd_i, rx_on_o, rx_exit_o, ldc_wake_o, ldc_en_o, multi_pkt_o;
   wire        fifo_clr_o, xtal_shift_o, ant1_o, ant2_o;
   integer     num_errors, total_checks, i, e;
   rmc_host_model u_host (.core_clk_i(core_clk_i), .addr_o(addr_i), .wdata_o(wdata_i),
      .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
   rmc_top #(.N_GPIO(3), .DWELL_CYC(4)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .rx_state_i(rx_state_i), .pkt_valid_i(pkt_valid_i),
      .preamble_det_i(preamble_det_i), .rssi_i(rssi_i), .wut_expire_i(wut_expire_i),
      .gpio_sel_i(gpio_sel_i), .gpio_ant_o(gpio_ant_o), .gpio_ant_oe_o(gpio_ant_oe_o),
      .rx_on_o(rx_on_o), .rx_exit_o(rx_exit_o), .ldc_wake_o(ldc_wake_o),
      .ldc_en_o(ldc_en_o), .multi_pkt_o(multi_pkt_o), .fifo_clr_o(fifo_clr_o),
      .xtal_trim_o(xtal_trim_o), .xtal_shift_o(xtal_shift_o), .ant1_o(ant1_o),
      .ant2_o(ant2_o));
   always #12.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) rssi_i <= rst_i ? 8'h00 : rssi_i + 8'h05;
   task chk(input [7:0] got, input [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] exp);
      u_host.rd(a, rv);
      chk(rv, exp);
   endtask
   task pkt;
      @(posedge core_clk_i) pkt_valid_i <= 1'b1;
      @(posedge core_clk_i) pkt_valid_i <= 1'b0;
      #1;
   endtask
   task wut;
      @(posedge core_clk_i) wut_expire_i <= 1'b1;
      @(posedge core_clk_i) wut_expire_i <= 1'b0;
      #1;
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk_i);
      num_errors = num_errors + 1;
      print_verdict;
   end
   initial begin
      {core_clk_i, rx_state_i, pkt_valid_i, preamble_det_i, wut_expire_i} = 5'h00;
      rst_i = 1'b1;
      ce_i = 1'b1;
      num_errors = 0;
      total_checks = 0;
      gpio_sel_i = {5'h16, `RMC_GPIO_ANT2, `RMC_GPIO_ANT1};
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rd_chk(`RMC_ADDR_RXCTRL, `RMC_RXCTRL_RST);
      rd_chk(`RMC_ADDR_XTAL, `RMC_XTAL_RST);
      rd_chk(8'h0A, `RMC_RDATA_NONE);
      for (i = 0; i < 2; i = i + 1) begin
         u_host.wr(`RMC_ADDR_XTAL, i ? 8'h7F : 8'h85);
         chk({1'b0, xtal_trim_o}, i ? 8'h7F : 8'h05);
         chk({7'h00, xtal_shift_o}, i ? 8'h00 : 8'h01);
         rd_chk(`RMC_ADDR_XTAL, i ? 8'h7F : 8'h85);
      end
      // a frozen block ignores the write and keeps its trim
      @(posedge core_clk_i) ce_i <= 1'b0;
      u_host.wr(`RMC_ADDR_XTAL, 8'h3C);
      chk({1'b0, xtal_trim_o}, 8'h7F);
      @(posedge core_clk_i) ce_i <= 1'b1;
      rd_chk(`RMC_ADDR_XTAL, 8'h7F);
      // fixed antenna levels outside receive for every code
      for (i = 0; i < 8; i = i + 1) begin
         e = (i == 2 || i == 3 || i == 5 || i == 7);
         u_host.wr(`RMC_ADDR_RXCTRL, {i[2:0], 5'h00});
         repeat (2) @(posedge core_clk_i);
         #1;
         chk({6'h00, ant1_o, ant2_o}, e ? 8'h03 : 8'h00);
         chk({2'b00, gpio_ant_oe_o, gpio_ant_o}, {5'b00011, 1'b0, e[0], e[0]});
      end
      u_host.wr(`RMC_ADDR_RXCTRL, 8'hC0);
      @(posedge core_clk_i) rx_state_i <= 1'b1;
      repeat (7) @(posedge core_clk_i);
      #1 chk({7'h00, ant1_o ^ ant2_o}, 8'h01);
      chk({6'h00, ant1_o, ant2_o}, 8'h01);
      @(posedge core_clk_i) preamble_det_i <= 1'b1;
      @(posedge core_clk_i) preamble_det_i <= 1'b0;
      rd_chk(`RMC_ADDR_STAT, 8'h0E);
      @(posedge core_clk_i) rx_state_i <= 1'b0;
      u_host.wr(`RMC_ADDR_DCFG, 8'h03);
      u_host.wr(`RMC_ADDR_RXCTRL, 8'h10);
      chk({7'h00, multi_pkt_o}, 8'h01);
      u_host.wr(`RMC_ADDR_OPMODE1, 8'h04);
      @(posedge core_clk_i) rx_state_i <= 1'b1;
      pkt;
      chk({7'h00, rx_exit_o}, 8'h00);
      rd_chk(`RMC_ADDR_OPMODE1, 8'h04);
      u_host.wr(`RMC_ADDR_RXCTRL, 8'h00);
      pkt;
      chk({7'h00, rx_exit_o}, 8'h01);
      rd_chk(`RMC_ADDR_OPMODE1, 8'h00);
      chk({7'h00, rx_on_o}, 8'h00);
      @(posedge core_clk_i) rx_state_i <= 1'b0;
      for (i = 1; i >= 0; i = i - 1) begin
         u_host.wr(`RMC_ADDR_RXCTRL, i ? 8'h04 : 8'h00);
         chk({7'h00, ldc_en_o}, i[7:0]);
         wut;
         chk({7'h00, ldc_wake_o}, i[7:0]);
      end
      u_host.wr(`RMC_ADDR_RXCTRL, 8'h02);
      repeat (3) @(posedge core_clk_i);
      #1 chk({7'h00, fifo_clr_o}, 8'h01);
      u_host.wr(`RMC_ADDR_RXCTRL, 8'h00);
      chk({7'h00, fifo_clr_o}, 8'h00);
      u_host.wr(`RMC_ADDR_OPMODE1, 8'h80);
      @(posedge core_clk_i);
      rd_chk(`RMC_ADDR_XTAL, `RMC_XTAL_RST);
      rd_chk(`RMC_ADDR_OPMODE1, `RMC_OPMODE1_RST);
      print_verdict;
   end
endmodule
